/* oefe_pkg.sv */
package oefe_pkg;

	// timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int SUSPEND_IDLE_NS = 3_000_000;
	localparam int LONG_SE0_NS     = 2_000_000;
	// least times round up to whole cycles
	localparam int SUSPEND_IDLE_CYCLES =
		(SUSPEND_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LONG_SE0_CYCLES =
		(LONG_SE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// bus geometry
	localparam int ADDR_W  = 12;
	localparam int DATA_W  = 32;
	localparam int STRB_W  = 4;
	localparam int FLAG_W  = 16;
	localparam int LINE_W  = 6;

	// register indices (command codes); byte address is four times these
	localparam int IDX_STATUS_RD  = 'h67;
	localparam int IDX_FLAGS_RD   = 'h68;
	localparam int IDX_ENABLES_RD = 'h69;
	localparam int IDX_CTRL_RD    = 'h6E;
	localparam int IDX_FLAGS_WR   = 'hE8;
	localparam int IDX_ENABLES_WR = 'hE9;
	localparam int IDX_CTRL_WR    = 'hEE;
	localparam logic [ADDR_W-1:0] ADDR_STATUS_RD  = ADDR_W'(4 * IDX_STATUS_RD);
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_RD   = ADDR_W'(4 * IDX_FLAGS_RD);
	localparam logic [ADDR_W-1:0] ADDR_ENABLES_RD = ADDR_W'(4 * IDX_ENABLES_RD);
	localparam logic [ADDR_W-1:0] ADDR_CTRL_RD    = ADDR_W'(4 * IDX_CTRL_RD);
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_WR   = ADDR_W'(4 * IDX_FLAGS_WR);
	localparam logic [ADDR_W-1:0] ADDR_ENABLES_WR = ADDR_W'(4 * IDX_ENABLES_WR);
	localparam logic [ADDR_W-1:0] ADDR_CTRL_WR    = ADDR_W'(4 * IDX_CTRL_WR);

	// flag and enable bit positions
	localparam int BIT_ID      = 0;
	localparam int BIT_VBUS    = 1;
	localparam int BIT_B_END   = 2;
	localparam int BIT_A_VALID = 3;
	localparam int BIT_B_VALID = 4;
	localparam int BIT_REMOTE  = 5;
	localparam int BIT_SUSPEND = 6;
	localparam int BIT_RESUME  = 7;
	localparam int BIT_SRP     = 8;
	localparam int BIT_SE0     = 9;
	localparam int BIT_TIMER   = 10;
	localparam int BIT_KIND    = 0;

	// reset values and implemented-bit masks
	localparam logic [FLAG_W-1:0] FLAGS_RESET   = 16'h0000;
	localparam logic [FLAG_W-1:0] ENABLES_RESET = 16'h0000;
	localparam logic [FLAG_W-1:0] CTRL_RESET    = 16'h0000;
	localparam logic [FLAG_W-1:0] USED_MASK     = 16'h07FF;
	localparam logic [FLAG_W-1:0] CTRL_MASK     = 16'h0001;

	// line states
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J   = 2'h1;
	localparam logic [1:0] LINE_K   = 2'h2;

	typedef struct packed {
		logic remote_connected;
		logic b_session_valid;
		logic a_session_valid;
		logic b_session_ended;
		logic vbus_level_valid;
		logic id_pin_level;
	} oefe_line_status_t;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [DATA_W-1:0] pwdata;
		logic [STRB_W-1:0] pstrb;
	} oefe_apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} oefe_apb_rsp_t;

	typedef enum logic [1:0] {
		BUS_ACTIVE    = 2'h0,
		BUS_SUSPENDED = 2'h1,
		BUS_RESUMED   = 2'h3
	} oefe_bus_state_t;

	// registers are 16 bits wide, so only lanes 0 and 1 matter
	function automatic logic [FLAG_W-1:0] lane_mask(
		input logic [STRB_W-1:0] strb);
		return {{8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic hits(input oefe_apb_req_t r,
		input logic [ADDR_W-1:0] a);
		return r.paddr == a;
	endfunction

endpackage

/* oefe_change_detect.sv */
module oefe_change_detect #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// levels watched and their change pulses
	input  wire logic [WIDTH-1:0] level_i,
	output logic      [WIDTH-1:0] change_o
);
	import oefe_pkg::*;

	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] prev_next;
	logic             armed_reg;
	logic             armed_next;

	if (WIDTH < 1) begin : g_bad_width
		$error("change detector needs at least one bit");
	end

	always_comb begin
		prev_next  = level_i;
		armed_next = 1'b1;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			prev_reg  <= '0;
			armed_reg <= 1'b0;
		end else begin
			prev_reg  <= prev_next;
			armed_reg <= armed_next;
		end
	end

	// the first cycle after reset only captures, so a strap level is no event
	assign change_o = armed_reg ? (level_i ^ prev_reg) : '0;

	AST_CHANGE_SEEN: assert property (@(posedge clock_i) disable iff (rst_i)
		armed_reg && $changed(level_i) |-> change_o == (level_i ^ $past(level_i)))
		else $error("level change not reported");

endmodule

/* oefe_hold_timer.sv */
module oefe_hold_timer #(
	parameter int LIMIT = 4
) (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// condition and one-shot when it has held LIMIT cycles
	input  wire logic cond_i,
	output logic      fire_o
);
	import oefe_pkg::*;

	localparam int CW = $clog2(LIMIT + 1);

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;

	if (LIMIT < 2) begin : g_bad_limit
		$error("hold limit must be at least two cycles");
	end

	// saturates, so a long hold fires only once
	always_comb begin
		count_next = count_reg;
		if (!cond_i) begin
			count_next = '0;
		end else if (count_reg != CW'(LIMIT)) begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign fire_o = cond_i && (count_reg == CW'(LIMIT - 1));

	AST_FIRE_ONCE: assert property (@(posedge clock_i) disable iff (rst_i)
		fire_o |=> !fire_o)
		else $error("hold timer fired twice in a row");

	AST_NO_EARLY_FIRE: assert property (@(posedge clock_i) disable iff (rst_i)
		fire_o |-> $past(cond_i))
		else $error("hold timer fired without a held condition");

endmodule

/* oefe_top.sv */
// Summary of operation
// - set suspend flag (bit 6) when bus idles longer than 3 ms
// - set remote-connect change flag (bit 5) on any change of that level
// - set B-session-valid change flag (bit 4) when that level toggles
// - set A-session-valid change flag (bit 3) when that level toggles
// - set B-session-end change flag (bit 2) when that level toggles
// - set VBUS-valid change flag (bit 1) when that level toggles
// - set ID change flag (bit 0) when the ID pin level changes
// - flags stay set until written with 1; writing 0 changes nothing
// - flags read at code 68, cleared by writing at code E8
// - enables read at code 69, written at E9; bits 15 to 11 reserved
// - enable bit 10 unmasks timer timeout; clear masks it
// - enable bit 9 unmasks the long SE0 flag
// - enable bit 8 unmasks remote session request detection
// - enable bit 7 unmasks resume; only J to K counts
// - enable bit 6 unmasks the suspend flag
// - enable bits 5 to 0 unmask the change flag at the same position
// - set timer timeout flag (bit 10) when the OTG timer expires
// - set SE0 flag (bit 9) after SE0 lasting more than 2 ms
// - set session-request flag (bit 8); control selects VBUS or data pulsing
// - set resume flag (bit 7) on J to K while suspended
module oefe_top #(
	parameter int SUSPEND_LIMIT = oefe_pkg::SUSPEND_IDLE_CYCLES + 1,
	parameter int SE0_LIMIT     = oefe_pkg::LONG_SE0_CYCLES + 1
) (
	// clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        rst_i,
	// register bus
	input  wire oefe_pkg::oefe_apb_req_t     apb_req_i,
	output oefe_pkg::oefe_apb_rsp_t          apb_rsp_o,
	// port status levels and line state
	input  wire oefe_pkg::oefe_line_status_t line_status_i,
	input  wire logic [1:0]                  line_state_i,
	// event sources
	input  wire logic                        timer_expired_i,
	input  wire logic                        vbus_pulse_i,
	input  wire logic                        dline_pulse_i,
	// interrupt request
	output logic                             irq_o
);
	import oefe_pkg::*;

	oefe_bus_state_t   state_reg;
	oefe_bus_state_t   state_next;
	logic [1:0]        prev_line_reg;
	logic [1:0]        prev_line_next;
	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic [FLAG_W-1:0] enables_reg;
	logic [FLAG_W-1:0] enables_next;
	logic [FLAG_W-1:0] ctrl_reg;
	logic [FLAG_W-1:0] ctrl_next;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic              irq_reg;
	logic              irq_next;

	logic              setup_ph;
	logic              access_ph;
	logic              wr_en;
	logic              rd_setup;
	logic              mapped;
	logic              flags_wr_hit;
	logic [FLAG_W-1:0] wr_lanes;
	logic [FLAG_W-1:0] clear_vec;
	logic [FLAG_W-1:0] set_vec;
	logic [FLAG_W-1:0] status_word;
	logic [LINE_W-1:0] status_change;
	logic [1:0]        pulse_change;
	logic [1:0]        pulse_rise;
	logic              srp_pulse;
	logic              idle_fire;
	logic              se0_fire;
	logic              enter_suspend;
	logic              resume_pulse;

	if (SUSPEND_LIMIT < 2 || SE0_LIMIT < 2) begin : g_bad_limits
		$error("hold limits must be at least two cycles");
	end

	// level watchers
	oefe_change_detect #(
		.WIDTH (LINE_W)
	) u_status_watch (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.level_i  (line_status_i),
		.change_o (status_change)
	);

	oefe_change_detect #(
		.WIDTH (2)
	) u_pulse_watch (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.level_i  ({vbus_pulse_i, dline_pulse_i}),
		.change_o (pulse_change)
	);

	// idle counting only runs while awake, so re-entry needs a fresh 3 ms
	oefe_hold_timer #(
		.LIMIT (SUSPEND_LIMIT)
	) u_idle_timer (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.cond_i  ((line_state_i == LINE_J) && (state_reg == BUS_ACTIVE)),
		.fire_o  (idle_fire)
	);

	oefe_hold_timer #(
		.LIMIT (SE0_LIMIT)
	) u_se0_timer (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.cond_i  (line_state_i == LINE_SE0),
		.fire_o  (se0_fire)
	);

	// session request: rising edge of the selected pulse kind
	assign pulse_rise = pulse_change & {vbus_pulse_i, dline_pulse_i};
	assign srp_pulse  = ctrl_reg[BIT_KIND] ? pulse_rise[1] : pulse_rise[0];

	// bus suspend and resume tracking
	always_comb begin
		state_next     = state_reg;
		prev_line_next = line_state_i;
		enter_suspend  = 1'b0;
		resume_pulse   = 1'b0;
		case (state_reg)
		BUS_ACTIVE: begin
			if (idle_fire) begin
				state_next    = BUS_SUSPENDED;
				enter_suspend = 1'b1;
			end
		end
		BUS_SUSPENDED: begin
			if (prev_line_reg == LINE_J && line_state_i == LINE_K) begin
				state_next   = BUS_RESUMED;
				resume_pulse = 1'b1;
			end else if (line_state_i != LINE_J) begin
				state_next = BUS_ACTIVE;
			end
		end
		BUS_RESUMED: begin
			state_next = BUS_ACTIVE;
		end
		default: begin
			state_next = BUS_ACTIVE;
		end
		endcase
	end

	// event collection
	always_comb begin
		set_vec                    = '0;
		set_vec[LINE_W-1:0]        = status_change;
		set_vec[BIT_SUSPEND]       = enter_suspend;
		set_vec[BIT_RESUME]        = resume_pulse;
		set_vec[BIT_SRP]           = srp_pulse;
		set_vec[BIT_SE0]           = se0_fire;
		set_vec[BIT_TIMER]         = timer_expired_i;
	end

	// apb decode; zero wait states
	assign setup_ph  = apb_req_i.psel && !apb_req_i.penable;
	assign access_ph = apb_req_i.psel && apb_req_i.penable;
	assign wr_en     = access_ph && apb_req_i.pwrite;
	assign rd_setup  = setup_ph && !apb_req_i.pwrite;
	assign wr_lanes  = lane_mask(apb_req_i.pstrb);
	assign flags_wr_hit = wr_en && hits(apb_req_i, ADDR_FLAGS_WR);

	always_comb begin
		if (apb_req_i.pwrite) begin
			mapped = hits(apb_req_i, ADDR_FLAGS_WR) ||
				hits(apb_req_i, ADDR_ENABLES_WR) ||
				hits(apb_req_i, ADDR_CTRL_WR);
		end else begin
			mapped = hits(apb_req_i, ADDR_STATUS_RD) ||
				hits(apb_req_i, ADDR_FLAGS_RD) ||
				hits(apb_req_i, ADDR_ENABLES_RD) ||
				hits(apb_req_i, ADDR_CTRL_RD);
		end
	end

	// status readback: live levels plus the suspended state
	always_comb begin
		status_word              = '0;
		status_word[LINE_W-1:0]  = line_status_i;
		status_word[BIT_SUSPEND] = (state_reg == BUS_SUSPENDED);
	end

	// register writes; hardware set beats a same-cycle clear
	always_comb begin
		clear_vec    = flags_wr_hit ? (apb_req_i.pwdata[FLAG_W-1:0] & wr_lanes) : '0;
		flags_next   = ((flags_reg & ~clear_vec) | set_vec) & USED_MASK;
		enables_next = enables_reg;
		ctrl_next    = ctrl_reg;
		if (wr_en && hits(apb_req_i, ADDR_ENABLES_WR)) begin
			enables_next = ((enables_reg & ~wr_lanes) |
				(apb_req_i.pwdata[FLAG_W-1:0] & wr_lanes)) & USED_MASK;
		end
		if (wr_en && hits(apb_req_i, ADDR_CTRL_WR)) begin
			ctrl_next = ((ctrl_reg & ~wr_lanes) |
				(apb_req_i.pwdata[FLAG_W-1:0] & wr_lanes)) & CTRL_MASK;
		end
	end

	// read data is latched in the setup cycle and shown in the access cycle
	always_comb begin
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = '0;
			if (hits(apb_req_i, ADDR_FLAGS_RD)) begin
				prdata_next[FLAG_W-1:0] = flags_reg;
			end else if (hits(apb_req_i, ADDR_ENABLES_RD)) begin
				prdata_next[FLAG_W-1:0] = enables_reg;
			end else if (hits(apb_req_i, ADDR_CTRL_RD)) begin
				prdata_next[FLAG_W-1:0] = ctrl_reg;
			end else if (hits(apb_req_i, ADDR_STATUS_RD)) begin
				prdata_next[FLAG_W-1:0] = status_word;
			end
		end
	end

	// one masked-or covers every enable position
	assign irq_next = |(flags_reg & enables_reg);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg     <= BUS_ACTIVE;
			prev_line_reg <= LINE_J;
			flags_reg     <= FLAGS_RESET;
			enables_reg   <= ENABLES_RESET;
			ctrl_reg      <= CTRL_RESET;
			prdata_reg    <= '0;
			irq_reg       <= 1'b0;
		end else begin
			state_reg     <= state_next;
			prev_line_reg <= prev_line_next;
			flags_reg     <= flags_next;
			enables_reg   <= enables_next;
			ctrl_reg      <= ctrl_next;
			prdata_reg    <= prdata_next;
			irq_reg       <= irq_next;
		end
	end

	assign apb_rsp_o.prdata  = prdata_reg;
	assign apb_rsp_o.pready  = 1'b1;
	assign apb_rsp_o.pslverr = access_ph && !mapped;
	assign irq_o             = irq_reg;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence s_rd_setup(logic [ADDR_W-1:0] a);
		rd_setup && apb_req_i.paddr == a;
	endsequence

	sequence s_full_write(logic [ADDR_W-1:0] a);
		wr_en && apb_req_i.paddr == a && apb_req_i.pstrb == 4'hF;
	endsequence

	AST_SUSPEND_FLAG: assert property (
		$rose(state_reg == BUS_SUSPENDED) |-> flags_reg[BIT_SUSPEND])
		else $error("suspend entry did not set its flag");
	AST_REMOTE_FLAG: assert property (
		$changed(line_status_i.remote_connected) && !$past(rst_i)
		|=> flags_reg[BIT_REMOTE])
		else $error("remote connect change not flagged");
	AST_B_VALID_FLAG: assert property (
		$changed(line_status_i.b_session_valid) && !$past(rst_i)
		|=> flags_reg[BIT_B_VALID])
		else $error("B session valid change not flagged");
	AST_A_VALID_FLAG: assert property (
		$changed(line_status_i.a_session_valid) && !$past(rst_i)
		|=> flags_reg[BIT_A_VALID])
		else $error("A session valid change not flagged");
	AST_B_END_FLAG: assert property (
		$changed(line_status_i.b_session_ended) && !$past(rst_i)
		|=> flags_reg[BIT_B_END])
		else $error("B session end change not flagged");
	AST_VBUS_FLAG: assert property (
		$changed(line_status_i.vbus_level_valid) && !$past(rst_i)
		|=> flags_reg[BIT_VBUS])
		else $error("VBUS valid change not flagged");
	AST_ID_FLAG: assert property (
		$changed(line_status_i.id_pin_level) && !$past(rst_i)
		|=> flags_reg[BIT_ID])
		else $error("ID change not flagged");
	AST_W1C_CLEAR: assert property (
		s_full_write(ADDR_FLAGS_WR) ##0 (set_vec == '0)
		|=> flags_reg == ($past(flags_reg) & ~$past(apb_req_i.pwdata[15:0])))
		else $error("write-one-to-clear misbehaved");
	AST_FLAGS_STICKY: assert property (
		!flags_wr_hit |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("flag dropped without a clearing write");
	AST_SET_WINS: assert property (
		(set_vec != '0) |=> (flags_reg & $past(set_vec)) == $past(set_vec))
		else $error("event lost against a clear");
	AST_FLAGS_READ: assert property (
		s_rd_setup(ADDR_FLAGS_RD) |=> apb_rsp_o.prdata == 32'($past(flags_reg)))
		else $error("flag read returned wrong data");
	AST_ENABLES_WRITE: assert property (
		s_full_write(ADDR_ENABLES_WR) |=> (enables_reg ==
		($past(apb_req_i.pwdata[15:0]) & USED_MASK)) && enables_reg[15:11] == '0)
		else $error("enable write not stored or reserved bits set");
	AST_TIMER_MASKED: assert property (
		!enables_reg[BIT_TIMER] && ((flags_reg & enables_reg) == '0) |=> !irq_o)
		else $error("masked timer event raised interrupt");
	AST_SE0_UNMASK: assert property (
		flags_reg[BIT_SE0] && enables_reg[BIT_SE0] |=> irq_o)
		else $error("unmasked SE0 event gave no interrupt");
	AST_SRP_UNMASK: assert property (
		flags_reg[BIT_SRP] && enables_reg[BIT_SRP] |=> irq_o)
		else $error("unmasked session request gave no interrupt");
	AST_RESUME_UNMASK: assert property (
		flags_reg[BIT_RESUME] && enables_reg[BIT_RESUME] |=> irq_o)
		else $error("unmasked resume gave no interrupt");
	AST_SUSPEND_UNMASK: assert property (
		flags_reg[BIT_SUSPEND] && enables_reg[BIT_SUSPEND] |=> irq_o)
		else $error("unmasked suspend gave no interrupt");
	AST_CHANGE_UNMASK: assert property (
		|(flags_reg[5:0] & enables_reg[5:0]) |=> irq_o)
		else $error("unmasked change flag gave no interrupt");
	AST_TIMER_FLAG: assert property (
		timer_expired_i |=> flags_reg[BIT_TIMER])
		else $error("timer expiry not flagged");
	AST_SE0_FLAG: assert property (
		se0_fire |-> (line_state_i == LINE_SE0) ##1 flags_reg[BIT_SE0])
		else $error("long SE0 not flagged");
	AST_SRP_DATA: assert property (
		!ctrl_reg[BIT_KIND] && $rose(dline_pulse_i) && !$past(rst_i)
		|=> flags_reg[BIT_SRP])
		else $error("data-line session request not flagged");
	AST_SRP_VBUS: assert property (
		ctrl_reg[BIT_KIND] && $rose(vbus_pulse_i) && !$past(rst_i)
		|=> flags_reg[BIT_SRP])
		else $error("VBUS session request not flagged");
	AST_RESUME_FLAG: assert property (
		state_reg == BUS_SUSPENDED && !$past(rst_i) &&
		$past(line_state_i) == LINE_J && line_state_i == LINE_K
		|=> flags_reg[BIT_RESUME] ##1 (state_reg == BUS_ACTIVE))
		else $error("resume while suspended not flagged");
	AST_IRQ_LEVEL: assert property (
		(|(flags_reg & enables_reg)) |=> irq_o)
		else $error("interrupt request missing");
	AST_IRQ_QUIET: assert property (
		((flags_reg & enables_reg) == '0) |=> !irq_o)
		else $error("interrupt request without cause");

endmodule

/* tb_otg_event_flags_and_enables.sv */
module tb_otg_event_flags_and_enables;
	timeunit 1ns;
	timeprecision 1ns;
	import oefe_pkg::*;

	// short hold limits keep the run brief; expectations use LIM
	localparam int LIM = 8;

	// clock and reset
	logic              clock_i;
	logic              rst_i;
	// design ports
	oefe_apb_req_t     req;
	oefe_apb_rsp_t     rsp;
	oefe_line_status_t ls;
	logic [1:0]        lstate;
	logic              tmr;
	logic              vbp;
	logic              dlp;
	logic              irq;
	// bookkeeping
	int                error_cnt;
	int                n_compared;
	logic [32:0]       expq[$];
	logic [15:0]       v;
	int                b;

	oefe_top #(
		.SUSPEND_LIMIT (LIM),
		.SE0_LIMIT     (LIM)
	) i_oefe_top (
		.clock_i         (clock_i),
		.rst_i           (rst_i),
		.apb_req_i       (req),
		.apb_rsp_o       (rsp),
		.line_status_i   (ls),
		.line_state_i    (lstate),
		.timer_expired_i (tmr),
		.vbus_pulse_i    (vbp),
		.dline_pulse_i   (dlp),
		.irq_o           (irq)
	);

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one transfer; expectation is {pslverr, read data}
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [15:0] d, input logic [32:0] exp);
		@(posedge clock_i);
		expq.push_back(exp);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
			pwdata: {16'hFFFF, d}, pstrb: 4'hF};
		@(posedge clock_i);
		req.penable <= 1'b1;
		@(posedge clock_i);
		while (rsp.pready !== 1'b1)
			@(posedge clock_i);
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		apb(a, 1'b0, 16'h0000, {17'h00000, e});
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(a, 1'b1, d, 33'h000000000);
	endtask

	// monitor: write data is not looked at, so only pslverr counts there
	always @(posedge clock_i) begin
		if (!rst_i && req.psel && req.penable && rsp.pready === 1'b1) begin
			if (expq.size() > 0)
				check({rsp.pslverr, req.pwrite ? 32'h0 : rsp.prdata},
					expq.pop_front());
		end
	end

	// raise the event behind flag bit n
	task automatic fire(input int n);
		@(posedge clock_i);
		if (n < 6) begin
			ls <= oefe_line_status_t'(ls ^ (6'h01 << n));
		end else if (n == BIT_SUSPEND) begin
			lstate <= LINE_J;
			repeat (LIM + 3) @(posedge clock_i);
		end else if (n == BIT_RESUME) begin
			lstate <= LINE_K;
		end else if (n == BIT_SRP) begin
			// kind select is 0 after reset, so the vbus pulse must not count
			vbp <= 1'b1;
			@(posedge clock_i);
			vbp <= 1'b0;
			dlp <= 1'b1;
			@(posedge clock_i);
			dlp <= 1'b0;
		end else if (n == BIT_SE0) begin
			lstate <= LINE_SE0;
			repeat (LIM + 3) @(posedge clock_i);
			lstate <= LINE_K;
		end else begin
			tmr <= 1'b1;
			@(posedge clock_i);
			tmr <= 1'b0;
		end
		repeat (3) @(posedge clock_i);
	endtask

	initial begin
		void'($urandom(6));
		error_cnt  = 0;
		n_compared = 0;
		rst_i      = 1'b1;
		req        = '0;
		ls         = oefe_line_status_t'(6'($urandom()));
		// K as resting line state: never idle J, never SE0
		lstate     = LINE_K;
		tmr        = 1'b0;
		vbp        = 1'b0;
		dlp        = 1'b0;
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		check({32'h0, irq}, 33'h0);
		rd(ADDR_FLAGS_RD, FLAGS_RESET);
		rd(ADDR_ENABLES_RD, ENABLES_RESET);
		apb(ADDR_ENABLES_WR, 1'b0, 16'h0000, {1'b1, 32'h0});
		apb(12'h000, 1'b1, 16'hFFFF, {1'b1, 32'h0});
		v = 16'($urandom());
		wr(ADDR_ENABLES_WR, v | 16'hF800);
		rd(ADDR_ENABLES_RD, (v | 16'hF800) & USED_MASK);
		// bits 0 to 5 come round twice so each level toggles both ways
		for (int k = 0; k < 17; k++) begin
			b = (k < 11) ? k : k - 11;
			wr(ADDR_ENABLES_WR, 16'h0001 << b);
			fire(b);
			check({32'h0, irq}, 33'h1);
			v = 16'($urandom()) & ~(16'h0001 << b);
			wr(ADDR_ENABLES_WR, v);
			repeat (3) @(posedge clock_i);
			check({32'h0, irq}, 33'h0);
			rd(ADDR_FLAGS_RD, 16'h0001 << b);
			wr(ADDR_FLAGS_WR, v);
			apb(ADDR_FLAGS_RD, 1'b1, 16'hFFFF, {1'b1, 32'h0});
			rd(ADDR_FLAGS_RD, 16'h0001 << b);
			wr(ADDR_FLAGS_WR, 16'h0001 << b);
			rd(ADDR_FLAGS_RD, 16'h0000);
		end
		// vbus pulsing selected: a data-line pulse must no longer count
		wr(ADDR_CTRL_WR, 16'h0001);
		rd(ADDR_CTRL_RD, 16'h0001);
		rd(ADDR_STATUS_RD, {10'h000, ls});
		dlp <= 1'b1;
		repeat (2) @(posedge clock_i);
		dlp <= 1'b0;
		repeat (3) @(posedge clock_i);
		rd(ADDR_FLAGS_RD, 16'h0000);
		vbp <= 1'b1;
		repeat (2) @(posedge clock_i);
		vbp <= 1'b0;
		repeat (3) @(posedge clock_i);
		rd(ADDR_FLAGS_RD, 16'h0001 << BIT_SRP);
		wr(ADDR_FLAGS_WR, 16'h0001 << BIT_SRP);
		rd(ADDR_FLAGS_RD, 16'h0000);
		repeat (2) @(posedge clock_i);
		finish_test();
	end

	// the sequence needs about six hundred cycles; far more means a hang
	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		finish_test();
	end
endmodule
